// File: rtu_pkg.sv
// Package for the serial telegram framer: timing, sizes, rate codes.
// Assumes a 25 MHz system clock; all counts derive from it.
package rtu_pkg;
  // System clock rate in Hz
  localparam int unsigned CLK_HZ = 25000000;
  // Rate selector codes
  typedef enum logic [2:0] {
    RATE_9600, RATE_19200, RATE_38400, RATE_57600, RATE_76800
  } rate_t;
  // One character is eleven bit times
  localparam int unsigned CHAR_BITS = 11;
  // Gap figure in half characters (3.5 chars = 7 halves)
  localparam int unsigned GAP_HALF_CHARS = 7;
  // Fixed character time above the 19200 rate, in ns
  localparam int unsigned CHAR_TIME_FAST_NS = 573000;
  // Fixed gap time above the 19200 rate, in ns
  localparam int unsigned FRAME_GAP_FAST_NS = 2005000;
  // Cycles of character time at each slow rate (longest rounds down)
  localparam int unsigned CHAR_CYC_9600 = CLK_HZ / 9600 * CHAR_BITS;
  localparam int unsigned CHAR_CYC_19200 = CHAR_CYC_9600 / 2;
  // Cycles of gap at 9600 (least time rounds up)
  localparam int unsigned GAP_CYC_9600 =
    (CHAR_CYC_9600 * GAP_HALF_CHARS + 1) / 2;
  // Fixed gap cycles for 19200 and faster, truncating division
  localparam int unsigned GAP_CYC_FAST =
    (FRAME_GAP_FAST_NS / 1000 * (CLK_HZ / 1000000));
  // Fixed char cycles for 19200 and faster
  localparam int unsigned CHAR_CYC_FAST =
    (CHAR_TIME_FAST_NS / 1000 * (CLK_HZ / 1000000));
  // Broadcast address and address range
  localparam logic [7:0] ADDR_BCAST = 8'h00;
  localparam logic [7:0] ADDR_MAX = 8'hf7;
  // CRC seed and reflected polynomial
  localparam logic [15:0] CRC_SEED = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  // Timer width, ample for the longest gap
  localparam int unsigned TMR_W = 20;
  // Reset value of the timer
  localparam logic [TMR_W-1:0] TMR_RST = '0;
endpackage : rtu_pkg

// File: rtu_stream_if.sv
// Byte stream carrier between the framer and its FIFO.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface rtu_stream_if #(parameter int W = 9);
  logic [W-1:0] data; // Payload word
  logic valid; // Word offered
  logic ready; // Word accepted
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : rtu_stream_if
`default_nettype wire

// File: rtu_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; read data comes from a register.
`timescale 1ns/1ps
`default_nettype none
module rtu_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Filling side
  rtu_stream_if.snk wr,
  // Draining side
  output logic [W-1:0] o_data,
  output logic o_valid,
  input wire logic i_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH]; // Storage
  logic [AW:0] wp_q, wp_d, rp_q, rp_d; // Pointers with wrap bit
  logic [W-1:0] out_q, out_d; // Registered head word
  logic ov_q, ov_d; // Head word valid
  logic full, empty, push, pop; // Flags

  // Flags and handshakes
  always_comb begin
    empty = (wp_q == rp_q);
    full = (wp_q[AW-1:0] == rp_q[AW-1:0]) && (wp_q[AW] != rp_q[AW]);
    push = wr.valid && !full;
    pop = !empty && (!ov_q || i_ready);
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
    out_d = pop ? mem_q[rp_q[AW-1:0]] : out_q;
    ov_d = pop ? 1'b1 : (i_ready ? 1'b0 : ov_q);
  end
  assign wr.ready = !full;

  // Pointer and head registers
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wp_q <= '0;
      rp_q <= '0;
      out_q <= '0;
      ov_q <= 1'b0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      out_q <= out_d;
      ov_q <= ov_d;
    end
  end

  // Storage write
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= wr.data;
    end
  end

  assign o_data = out_q;
  assign o_valid = ov_q;
endmodule : rtu_fifo
`default_nettype wire

// File: rtu_serial_slave_framer.sv
// Slave-side telegram framer for a binary serial line.
// Assumes bytes arrive from a UART on the same clock; rate from config.
//
// Behaviour
// - Binary mode only; no text mode
// - Reply first byte is own address
// - Address zero is broadcast; never answered
// - Two CRC bytes end telegram, low first
// - Silence of 3.5 chars separates telegrams
// - First byte after gap is address
// - Gap after last byte completes telegram
// - Long inner gap restarts telegram assembly
// - Above 19200 timing stays at 19200 values
// - Fast rates use 573us and 2.005ms
// - One master, at most 247 slaves
// - Order: address, data unit, check field
// - Rates 9600 to 76800 selectable
// - Slave address in 1 to 247; i_own_addr is not range-checked
`timescale 1ns/1ps
`default_nettype none
module rtu_serial_slave_framer #(
  parameter int FIFO_DEPTH = 4,
  parameter int unsigned GAP_SLOW = rtu_pkg::GAP_CYC_9600,
  parameter int unsigned GAP_FAST = rtu_pkg::GAP_CYC_FAST
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Configuration
  input wire logic [2:0] i_rate,
  input wire logic [7:0] i_own_addr,
  // Received bytes from UART
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_valid,
  // Accepted telegram bytes out (bit 8 marks last)
  output logic [7:0] o_msg_data,
  output logic o_msg_last,
  output logic o_msg_valid,
  input wire logic i_msg_ready,
  // Telegram result events
  output logic o_msg_ok,
  output logic o_msg_bcast,
  output logic o_msg_drop,
  // Reply payload in (data unit only)
  input wire logic [7:0] i_rep_data,
  input wire logic i_rep_valid,
  input wire logic i_rep_last,
  output logic o_rep_ready,
  // Bytes to the UART transmitter
  output logic [7:0] o_tx_data,
  output logic o_tx_valid,
  input wire logic i_tx_ready,
  // Line idle indicator
  output logic o_idle
);
  typedef enum logic [1:0] {RX_IDLE, RX_COLLECT, RX_SKIP} rx_t;
  typedef enum logic [2:0] {TX_IDLE, TX_ADDR, TX_DATA, TX_CRCL, TX_CRCH}
    tx_t;

  // Reflected CRC-16 of one byte
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ rtu_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_step

  // Stream into FIFO
  rtu_stream_if #(.W(9)) fifo_in ();
  logic [8:0] fifo_out; // FIFO head word
  logic fifo_ov; // FIFO head valid

  // Receive state
  rx_t rx_q, rx_d; // Receive FSM
  logic [rtu_pkg::TMR_W-1:0] tmr_q, tmr_d; // Silence timer
  logic [15:0] crc_q, crc_d; // Running CRC
  logic [7:0] addr_q, addr_d; // Captured address
  logic [15:0] tail_q, tail_d; // Last two bytes
  logic [7:0] cnt_q, cnt_d; // Byte count, saturating
  logic [7:0] hold_q, hold_d; // Byte held back from FIFO
  logic hv_q, hv_d; // Hold valid
  logic mine; // Address accepted
  logic [rtu_pkg::TMR_W-1:0] gap_cyc; // Active gap threshold
  logic gap_hit; // Silence reached
  logic ok_q, ok_d, bc_q, bc_d, dr_q, dr_d; // Result pulses
  logic push_v; // Push to FIFO
  logic [8:0] push_w; // Word pushed
  logic ovf_q, ovf_d; // FIFO refused a byte
  logic idle_q, idle_d; // Registered line idle flag

  // Gap threshold per rate; fast rates clamp to fixed time
  always_comb begin
    if (i_rate == 3'(rtu_pkg::RATE_9600)) begin
      gap_cyc = rtu_pkg::TMR_W'(GAP_SLOW);
    end else begin
      gap_cyc = rtu_pkg::TMR_W'(GAP_FAST);
    end
    gap_hit = (tmr_q >= gap_cyc);
  end

  // Receive framing: next state
  always_comb begin
    rx_d = rx_q;
    tmr_d = gap_hit ? tmr_q : tmr_q + 1'b1;
    crc_d = crc_q;
    addr_d = addr_q;
    tail_d = tail_q;
    cnt_d = cnt_q;
    hold_d = hold_q;
    hv_d = hv_q;
    ok_d = 1'b0;
    bc_d = 1'b0;
    dr_d = 1'b0;
    ovf_d = ovf_q;
    push_v = 1'b0;
    push_w = {1'b0, hold_q};
    // Own address (1 to 247) or broadcast
    mine = (addr_q == i_own_addr) || (addr_q == rtu_pkg::ADDR_BCAST);
    if (i_rx_valid) begin
      tmr_d = '0;
      if (rx_q == RX_IDLE || gap_hit) begin
        // First byte after silence is the address
        rx_d = RX_COLLECT;
        addr_d = i_rx_data;
        crc_d = crc_step(rtu_pkg::CRC_SEED, i_rx_data);
        // Newest byte sits in the upper half
        tail_d = {i_rx_data, 8'h00};
        cnt_d = 8'd1;
        hv_d = 1'b0;
        ovf_d = 1'b0;
      end else if (rx_q == RX_COLLECT) begin
        crc_d = crc_step(crc_q, i_rx_data);
        tail_d = {i_rx_data, tail_q[15:8]}; // Low CRC first
        cnt_d = (cnt_q == 8'hff) ? cnt_q : cnt_q + 1'b1;
        // Delay by two so the CRC bytes never reach the FIFO
        if (cnt_q >= 8'd2 && mine) begin
          push_v = hv_q;
          if (hv_q && !fifo_in.ready) begin
            ovf_d = 1'b1;
          end
        end
        // Hold the byte two back; it is payload once this one came
        hold_d = tail_q[7:0];
        hv_d = (cnt_q >= 8'd3);
      end
    end else if (rx_q == RX_COLLECT && gap_hit) begin
      // Silence closes the telegram
      rx_d = RX_IDLE;
      // A full FIFO would lose the last byte, so drop instead
      if (cnt_q >= 8'd4 && crc_q == 16'h0000 && mine && !ovf_q &&
          fifo_in.ready) begin
        ok_d = 1'b1;
        bc_d = (addr_q == rtu_pkg::ADDR_BCAST);
        push_v = 1'b1;
        push_w = {1'b1, hold_q};
      end else begin
        dr_d = 1'b1;
      end
      hv_d = 1'b0;
    end
    // Idle flag follows the next receive state
    idle_d = (rx_d == RX_IDLE);
  end

  assign fifo_in.data = push_w;
  assign fifo_in.valid = push_v;

  // Receive framing registers
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_q <= RX_IDLE;
      tmr_q <= rtu_pkg::TMR_RST;
      crc_q <= rtu_pkg::CRC_SEED;
      addr_q <= 8'h00;
      tail_q <= 16'h0000;
      cnt_q <= 8'h00;
      hold_q <= 8'h00;
      hv_q <= 1'b0;
      ok_q <= 1'b0;
      bc_q <= 1'b0;
      dr_q <= 1'b0;
      ovf_q <= 1'b0;
      idle_q <= 1'b1;
    end else begin
      rx_q <= rx_d;
      tmr_q <= tmr_d;
      crc_q <= crc_d;
      addr_q <= addr_d;
      tail_q <= tail_d;
      cnt_q <= cnt_d;
      hold_q <= hold_d;
      hv_q <= hv_d;
      ok_q <= ok_d;
      bc_q <= bc_d;
      dr_q <= dr_d;
      ovf_q <= ovf_d;
      idle_q <= idle_d;
    end
  end

  // Buffer between framing and consumer
  rtu_fifo #(.W(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .wr(fifo_in),
    .o_data(fifo_out),
    .o_valid(fifo_ov),
    .i_ready(i_msg_ready)
  );

  // Transmit state
  tx_t tx_q, tx_d; // Transmit FSM
  logic [15:0] tcrc_q, tcrc_d; // Transmit CRC
  logic [7:0] txd_q, txd_d; // Byte on offer
  logic txv_q, txv_d; // Offer valid
  logic rr_q, rr_d; // Reply ready
  logic blast_q, blast_d; // Last payload seen
  logic lastbc_q, lastbc_d; // Blocks reply: set by reset, an accepted broadcast or a sent reply

  // Reply framing: address, payload, CRC low then high
  always_comb begin
    tx_d = tx_q;
    tcrc_d = tcrc_q;
    txd_d = txd_q;
    txv_d = txv_q;
    rr_d = 1'b0;
    blast_d = blast_q;
    lastbc_d = ok_q ? bc_q : lastbc_q;
    case (tx_q)
      TX_IDLE: begin
        // No reply ever follows a broadcast
        if (i_rep_valid && !lastbc_q && rx_q == RX_IDLE) begin
          tx_d = TX_ADDR;
          txd_d = i_own_addr;
          txv_d = 1'b1;
          tcrc_d = crc_step(rtu_pkg::CRC_SEED, i_own_addr);
          blast_d = 1'b0;
        end
      end
      TX_ADDR: begin
        if (i_tx_ready) begin
          txv_d = 1'b0;
          tx_d = TX_DATA;
          rr_d = 1'b1;
        end
      end
      TX_DATA: begin
        if (txv_q) begin
          if (i_tx_ready) begin
            txv_d = 1'b0;
            rr_d = !blast_q;
            if (blast_q) begin
              tx_d = TX_CRCL;
              txd_d = tcrc_q[7:0];
              txv_d = 1'b1;
            end
          end
        end else if (rr_q && i_rep_valid) begin
          txd_d = i_rep_data;
          txv_d = 1'b1;
          tcrc_d = crc_step(tcrc_q, i_rep_data);
          blast_d = i_rep_last;
        end else begin
          rr_d = 1'b1;
        end
      end
      TX_CRCL: begin
        if (i_tx_ready) begin
          tx_d = TX_CRCH;
          txd_d = tcrc_q[15:8];
        end
      end
      default: begin
        if (i_tx_ready) begin
          txv_d = 1'b0;
          tx_d = TX_IDLE;
          lastbc_d = 1'b1; // One reply per request
        end
      end
    endcase
  end

  // Reply framing registers
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_q <= TX_IDLE;
      tcrc_q <= rtu_pkg::CRC_SEED;
      txd_q <= 8'h00;
      txv_q <= 1'b0;
      rr_q <= 1'b0;
      blast_q <= 1'b0;
      lastbc_q <= 1'b1;
    end else begin
      tx_q <= tx_d;
      tcrc_q <= tcrc_d;
      txd_q <= txd_d;
      txv_q <= txv_d;
      rr_q <= rr_d;
      blast_q <= blast_d;
      lastbc_q <= lastbc_d;
    end
  end

  // Output wiring from flip-flops
  assign o_msg_data = fifo_out[7:0];
  assign o_msg_last = fifo_out[8];
  assign o_msg_valid = fifo_ov;
  assign o_msg_ok = ok_q;
  assign o_msg_bcast = bc_q;
  assign o_msg_drop = dr_q;
  assign o_rep_ready = rr_q;
  assign o_tx_data = txd_q;
  assign o_tx_valid = txv_q;
  assign o_idle = idle_q;
endmodule : rtu_serial_slave_framer
`default_nettype wire

// File: rtu_frame_props.sv
// Checker for the framer's top ports.
// Assumes a bind onto the framer; one clock.
`timescale 1ns/1ps
`default_nettype none
module rtu_frame_props #(
  parameter int unsigned GAP_SLOW = 200,
  parameter int unsigned GAP_FAST = 100
) (
  // Clock, reset and rate
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [2:0] i_rate,
  // Receive and result side
  input wire logic i_rx_valid,
  input wire logic [7:0] o_msg_data,
  input wire logic o_msg_valid,
  input wire logic i_msg_ready,
  input wire logic o_msg_ok,
  input wire logic o_msg_bcast,
  input wire logic o_msg_drop,
  // Transmit side
  input wire logic [7:0] o_tx_data,
  input wire logic o_tx_valid,
  input wire logic i_tx_ready,
  input wire logic o_idle
);
  logic [19:0] quiet_q, quiet_d; // Cycles since last byte
  logic [19:0] gap_w; // Gap for the rate
  assign gap_w = (i_rate == 3'h0) ? 20'(GAP_SLOW) : 20'(GAP_FAST);
  // Silence counter, saturating
  always_comb begin
    quiet_d = quiet_q;
    if (i_rx_valid) quiet_d = 20'h1;
    else if (quiet_q != '1) quiet_d = quiet_q + 20'h1;
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) quiet_q <= '1;
    else quiet_q <= quiet_d;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  res_excl_a: assert property (!(o_msg_ok && o_msg_drop))
    else $error("ok with drop");
  bcast_ok_a: assert property (o_msg_bcast |-> o_msg_ok)
    else $error("bcast without ok");
  res_pulse_a: assert property ((o_msg_ok || o_msg_drop) |=>
    !(o_msg_ok || o_msg_drop)) else $error("result not a pulse");
  res_time_a: assert property ((o_msg_ok || o_msg_drop) |->
    quiet_q == gap_w + 20'h2) else $error("result off gap");
  rx_busy_a: assert property (i_rx_valid |=> !o_idle)
    else $error("idle after byte");
  tx_hold_a: assert property (o_tx_valid && !i_tx_ready |=>
    o_tx_valid && $stable(o_tx_data)) else $error("tx dropped");
  msg_hold_a: assert property (o_msg_valid && !i_msg_ready |=>
    o_msg_valid && $stable(o_msg_data)) else $error("msg dropped");
  tx_idle_a: assert property ($rose(o_tx_valid) |-> o_idle)
    else $error("tx during rx");
  cover property (o_msg_ok);
  cover property (o_msg_bcast);
  cover property (o_msg_drop);
  cover property (o_tx_valid && i_tx_ready);
endmodule : rtu_frame_props
`default_nettype wire

// File: rtu_master_model.sv
// Bus master model: sends telegrams, sinks replies.
// Assumes the framer's clock; replies stall at random.
`timescale 1ns/1ps
`default_nettype none
module rtu_master_model (
  // Clock
  input wire logic i_clk,
  // Reply bytes in
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  // Request bytes out
  output logic [7:0] o_rx_data,
  output logic o_rx_valid
);
  logic [7:0] got_q[$]; // Reply bytes seen
  integer seed = 32'ha734ef2c; // Stall seed
  initial begin
    o_rx_data = 8'h00;
    o_rx_valid = 1'b0;
  end
  // Reply sink with random stalls
  always @(posedge i_clk) begin
    if (i_tx_valid && o_tx_ready) got_q.push_back(i_tx_data);
    o_tx_ready <= ($random(seed) % 3) != 0;
  end
  // Reflected check word, seeded all ones
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i]) begin
      c ^= {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction : crc16
  // One pulse per byte; released line shows inverse
  task automatic send(input logic [7:0] b[$], input int sp);
    foreach (b[i]) begin
      @(posedge i_clk);
      o_rx_data <= b[i];
      o_rx_valid <= 1'b1;
      @(posedge i_clk);
      o_rx_valid <= 1'b0;
      o_rx_data <= ~b[i];
      repeat (sp) @(posedge i_clk);
    end
  endtask : send
  // Address first, check word last, low byte first
  task automatic frame(input logic [7:0] b[$], input logic bad);
    logic [15:0] c;
    c = crc16(b) ^ {15'h0, bad};
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
    send(b, 3);
  endtask : frame
endmodule : rtu_master_model
`default_nettype wire

// File: tb_top.sv
// Bench for the framer: master model, consumer, checks.
// Assumes framer, FIFO, interface and model compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int GS = 200; // Short slow gap
  localparam int GF = 100; // Short fast gap
  logic i_clk, i_rstn, i_rx_valid, o_msg_last, o_msg_valid, i_msg_ready;
  logic o_msg_ok, o_msg_bcast, o_msg_drop, i_rep_valid, i_rep_last;
  logic o_rep_ready, o_tx_valid, i_tx_ready, o_idle, stall;
  logic [2:0] i_rate;
  logic [7:0] i_own_addr, i_rx_data, o_msg_data, i_rep_data, o_tx_data;
  logic [8:0] msg_q[$]; // Drained words
  logic [7:0] frm[$]; // Last telegram body
  integer seed = 32'ha734ef2c;
  int cyc, t_rx, t_res, n_ok, n_bc, n_drop, mismatches, num_checks;
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  rtu_serial_slave_framer #(.FIFO_DEPTH(4), .GAP_SLOW(GS), .GAP_FAST(GF))
    dut_u (.i_clk, .i_rstn, .i_rate, .i_own_addr, .i_rx_data, .i_rx_valid,
    .o_msg_data, .o_msg_last, .o_msg_valid, .i_msg_ready, .o_msg_ok,
    .o_msg_bcast, .o_msg_drop, .i_rep_data, .i_rep_valid, .i_rep_last,
    .o_rep_ready, .o_tx_data, .o_tx_valid, .i_tx_ready, .o_idle);
  rtu_master_model mdl_u (.i_clk, .i_tx_data(o_tx_data),
    .i_tx_valid(o_tx_valid), .o_tx_ready(i_tx_ready),
    .o_rx_data(i_rx_data), .o_rx_valid(i_rx_valid));
  // Event log and random consumer
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (i_rx_valid) t_rx <= cyc;
    if (o_msg_ok || o_msg_drop) t_res <= cyc;
    if (o_msg_ok) n_ok <= n_ok + 1;
    if (o_msg_bcast) n_bc <= n_bc + 1;
    if (o_msg_drop) n_drop <= n_drop + 1;
    if (o_msg_valid && i_msg_ready) msg_q.push_back({o_msg_last, o_msg_data});
    i_msg_ready <= !stall && ($random(seed) % 2 != 0);
  end
  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Result latency for a rate code
  function automatic int lat(input logic [2:0] r);
    return (r == 3'h0 ? GS : GF) + 2;
  endfunction : lat
  // Bounded wait for one result, then let the FIFO drain
  task automatic wait_res();
    int n0;
    n0 = n_ok + n_drop;
    for (int k = 0; k < 2 * GS && n_ok + n_drop == n0; k++) @(posedge i_clk);
    repeat (20) @(posedge i_clk);
  endtask : wait_res
  // One telegram with random data unit, then its checks
  task automatic tele(input logic [7:0] a, int np, logic bad, logic ok_e);
    int k0, d0, b0;
    frm = {a};
    repeat (np) frm.push_back(8'($random(seed)));
    msg_q = {};
    k0 = n_ok;
    d0 = n_drop;
    b0 = n_bc;
    mdl_u.frame(frm, bad);
    wait_res();
    chk("ok", 32'(ok_e), 32'(n_ok - k0));
    chk("drop", 32'(!ok_e), 32'(n_drop - d0));
    chk("bc", 32'(ok_e && a == 8'h00), 32'(n_bc - b0));
    chk("gap", 32'(lat(i_rate)), 32'(t_res - t_rx));
    // Payload streams before the check; a dropped own telegram leaves
    // all but its held last byte, unless the consumer is stalled
    chk("len", 32'(stall ? 0 : ok_e ? np : (a == i_own_addr ? np - 1 : 0)),
      32'(msg_q.size()));
    foreach (msg_q[i]) chk("b", {i == np - 1, frm[i + 1]}, msg_q[i]);
  endtask : tele
  // Offer a reply data unit; expect a framed reply or none
  task automatic reply(input int np, input logic en);
    logic [7:0] r[$], e[$];
    logic [15:0] c;
    int k;
    repeat (np) r.push_back(8'($random(seed)));
    e = {i_own_addr, r};
    c = mdl_u.crc16(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    mdl_u.got_q = {};
    foreach (r[i]) begin
      i_rep_data <= r[i];
      i_rep_last <= (i == np - 1);
      i_rep_valid <= 1'b1;
      k = 0;
      do begin
        @(posedge i_clk);
        k++;
      end while (!o_rep_ready && k < 300);
    end
    i_rep_valid <= 1'b0;
    repeat (60) @(posedge i_clk);
    if (!en) e = {};
    chk("txn", 32'(e.size()), 32'(mdl_u.got_q.size()));
    foreach (e[i]) chk("tx", 32'(e[i]), 32'(mdl_u.got_q[i]));
  endtask : reply
  task automatic conclude();
    if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  // Watchdog
  initial begin
    repeat (60000) @(posedge i_clk);
    mismatches++;
    conclude();
  end
  // Main sequence
  initial begin
    int d;
    i_rstn = 1'b0;
    i_rate = 3'h1;
    i_own_addr = 8'h2a;
    i_rep_data = 8'h00;
    i_rep_valid = 1'b0;
    i_rep_last = 1'b0;
    stall = 1'b0;
    repeat (10) @(posedge i_clk);
    chk("idle", 32'h1, 32'(o_idle));
    i_rstn <= 1'b1;
    for (int r = 4; r >= 0; r--) begin
      i_rate <= 3'(r);
      repeat (GS) @(posedge i_clk);
      tele(i_own_addr, 2, 1'b0, 1'b1);
    end
    // Broadcast right after an unanswered request, so only it blocks
    tele(8'h00, 3, 1'b0, 1'b1);
    reply(1, 1'b0);
    tele(i_own_addr, 1, 1'b0, 1'b1);
    reply(2, 1'b1);
    tele(8'h2b, 2, 1'b0, 1'b0);
    tele(i_own_addr, 2, 1'b1, 1'b0);
    d = n_drop;
    mdl_u.send({i_own_addr, 8'h03}, 3);
    repeat (lat(i_rate) + 5) @(posedge i_clk);
    tele(i_own_addr, 3, 1'b0, 1'b1);
    chk("frag", 32'h1, 32'(n_drop - d));
    stall <= 1'b1;
    tele(i_own_addr, 6, 1'b0, 1'b0);
    stall <= 1'b0;
    repeat (60) @(posedge i_clk);
    // Four stored words plus the registered head word
    chk("fill", 32'h5, 32'(msg_q.size()));
    foreach (msg_q[i]) chk("fifo", 32'(frm[i + 1]), 32'(msg_q[i]));
    chk("empty", 32'h0, 32'(o_msg_valid));
    conclude();
  end
endmodule : tb_top
bind rtu_serial_slave_framer rtu_frame_props #(.GAP_SLOW(GAP_SLOW),
  .GAP_FAST(GAP_FAST)) props_u (.i_clk, .i_rstn, .i_rate, .i_rx_valid,
  .o_msg_data, .o_msg_valid, .i_msg_ready, .o_msg_ok, .o_msg_bcast,
  .o_msg_drop, .o_tx_data, .o_tx_valid, .i_tx_ready, .o_idle);
`default_nettype wire
